/* File: src/tsc_pkg.sv */
// Purpose: Shared constants, types and CRC function for the thermometer slave
// Assumes: 10 MHz system clock
// Notes: Times are kept in microseconds and turned into cycle counts here

package tsc_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 10;
   localparam int T_RST_US = 480;
   localparam int RST_CYC = T_RST_US * CLK_MHZ;
   localparam int T_SAMP_US = 30;
   localparam int SAMP_CYC = T_SAMP_US * CLK_MHZ;
   localparam int T_PDLY_US = 30;
   localparam int PDLY_CYC = T_PDLY_US * CLK_MHZ;
   localparam int T_PLEN_US = 120;
   localparam int PLEN_CYC = T_PLEN_US * CLK_MHZ;
   localparam int T_CONV_US = 750000;
   localparam int CONV_CYC = T_CONV_US * CLK_MHZ;

   // ==========================================================
   // Command codes
   localparam logic [7:0] CMD_SEARCH = 8'hf0;
   localparam logic [7:0] CMD_RROM = 8'h33;
   localparam logic [7:0] CMD_MATCH = 8'h55;
   localparam logic [7:0] CMD_SKIP = 8'hcc;
   localparam logic [7:0] CMD_ALARM = 8'hec;
   localparam logic [7:0] CMD_CONV = 8'h44;
   localparam logic [7:0] CMD_WR = 8'h4e;
   localparam logic [7:0] CMD_RD = 8'hbe;
   localparam logic [7:0] CMD_COPY = 8'h48;

   // ==========================================================
   // Scratchpad layout and reset values
   localparam int CFG_RH_BIT = 6;
   localparam int CFG_RL_BIT = 5;
   localparam logic [4:0] CFG_ONES = 5'h1f;
   localparam logic [1:0] RES_RST = 2'b11;
   localparam logic [15:0] TEMP_RST = 16'h0550;
   localparam logic [7:0] TH_RST = 8'h7f;
   localparam logic [7:0] TL_RST = 8'h80;
   localparam logic [23:0] SP_RSV = 24'hff_ff_ff;
   localparam logic [15:0] TEMP_LSB_MASK = 16'h0007;

   typedef struct packed {
      logic [23:0] rsv;
      logic [7:0] cfg;
      logic [7:0] tl;
      logic [7:0] th;
      logic [15:0] temp;
   } tsc_sp_t;

   typedef enum logic [10:0] {
      ST_IDLE = 11'h001,
      ST_RSTW = 11'h002,
      ST_PDLY = 11'h004,
      ST_PRES = 11'h008,
      ST_ROMC = 11'h010,
      ST_RROM = 11'h020,
      ST_MATCH = 11'h040,
      ST_SRCH = 11'h080,
      ST_FUNC = 11'h100,
      ST_WR = 11'h200,
      ST_RD = 11'h400
   } tsc_state_t;

   // Serial CRC x^8+x^5+x^4+1, preset zero, LSB first
   function automatic logic [7:0] tsc_crc8(input logic [71:0] d, input int n);
      logic [7:0] c;
      logic fb;
      c = 8'h00;
      for (int i = 0; i < 72; i++) begin
         if (i < n) begin
            fb = c[0] ^ d[i];
            c = {1'b0, c[7:1]};
            if (fb) begin
               c = c ^ 8'h8c;
            end
         end
      end
      return c;
   endfunction

endpackage

/* File: src/tsc_pin.sv */
// Purpose: Line front end: synchroniser, edges, sample point, long-low reset
// Assumes: Line idles high through an external pullup
// Notes: Level changes only once the 2nd and 3rd stages agree

module tsc_pin #(
   parameter int RST_CYC = tsc_pkg::RST_CYC
) (
   input wire logic clk, // System clock
   input wire logic srst, // Sync reset
   input wire logic dq_in, // Raw line level
   output logic lvl, // Filtered line level
   output logic fall, // Falling edge pulse
   output logic rise, // Rising edge pulse
   output logic samp, // Slot sample point pulse
   output logic breset // Long-low reset pulse
);
   import tsc_pkg::*;

   localparam int LW = $clog2(RST_CYC + 1);
   logic s1, s2, s3;
   logic [LW-1:0] lcnt;
   logic [8:0] scnt;
   logic sact;

   always_ff @(posedge clk) begin
      if (srst) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
      end else begin
         s1 <= dq_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         lvl <= 1'b1;
      end else if (s2 == s3) begin
         lvl <= s3;
      end
   end

   assign fall = (s2 == s3) & ~s3 & lvl;
   assign rise = (s2 == s3) & s3 & ~lvl;

   // Any gap between slots is fine: nothing times out while high
   always_ff @(posedge clk) begin
      if (srst) begin
         sact <= 1'b0;
         scnt <= 9'h000;
      end else if (fall) begin
         sact <= 1'b1;
         scnt <= 9'h000;
      end else if (sact) begin
         if (samp) begin
            sact <= 1'b0;
         end
         scnt <= scnt + 9'h001;
      end
   end

   assign samp = sact && (scnt == 9'(SAMP_CYC - 1));

   always_ff @(posedge clk) begin
      if (srst || lvl) begin
         lcnt <= '0;
      end else if (lcnt != LW'(RST_CYC)) begin
         lcnt <= lcnt + LW'(1);
      end
   end

   assign breset = !lvl && (lcnt == LW'(RST_CYC - 1));

endmodule

/* File: src/tsc_therm.sv */
// Purpose: Slave protocol and command layer of a single-wire thermometer
// Assumes: Temperature word arrives ready on temp_in from the sensing front end
// Notes: Conversion keeps running even if the line is reset meanwhile

module tsc_therm #(
   parameter logic [7:0] FAMILY = 8'h5a, // Arbitrary value
   parameter logic [47:0] SERIAL = 48'h0000_0000_0001, // Arbitrary value
   parameter int RST_CYC = tsc_pkg::RST_CYC,
   parameter int CONV_CYC = tsc_pkg::CONV_CYC
) (
   input wire logic clk, // 10 MHz clock
   input wire logic srst, // Sync reset, high
   input wire logic dq_in, // Line level in
   output logic dq_out, // Line drive value, always low
   output logic dq_oe, // High while pulling the line low
   input wire logic [15:0] temp_in, // Measured temperature word
   output logic conv_busy, // Conversion running
   output logic alarm_flag, // Alarm from latest conversion
   output tsc_pkg::tsc_sp_t nv_image // Nonvolatile copy contents
);
   import tsc_pkg::*;

   localparam int CW = $clog2(CONV_CYC + 1);
   localparam logic [7:0] ROM_CRC = tsc_crc8({16'h0000, SERIAL, FAMILY}, 56);
   localparam logic [63:0] ROM = {ROM_CRC, SERIAL, FAMILY};

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   tsc_state_t st;
   logic lvl, fall, rise, samp, breset;
   logic [10:0] cnt;
   logic [6:0] bcnt;
   logic [1:0] ph;
   logic [7:0] sh;
   logic [7:0] rx_byte;
   logic miss;
   logic drive;
   logic [7:0] th, tl;
   logic [1:0] res;
   logic [15:0] temp;
   logic [CW-1:0] conv_cnt;
   logic tx_en, tx_now, conv_go, copy_go, rom_bit;
   logic [7:0] cfg_byte;
   tsc_sp_t sp;
   logic [71:0] sp72;

   function automatic logic func_done(input tsc_state_t s, input logic sm,
                                      input logic [6:0] b, input logic [7:0] rx,
                                      input logic [7:0] code);
      return sm && s == ST_FUNC && b == 7'd7 && rx == code;
   endfunction

   tsc_pin #(
      .RST_CYC(RST_CYC)
   ) u_pin (
      .clk(clk),
      .srst(srst),
      .dq_in(dq_in),
      .lvl(lvl),
      .fall(fall),
      .rise(rise),
      .samp(samp),
      .breset(breset)
   );

   // ==========================================================
   // Scratchpad image
   assign cfg_byte = {1'b0, res, CFG_ONES};
   assign sp = '{rsv: SP_RSV, cfg: cfg_byte, tl: tl, th: th, temp: temp};
   assign sp72 = {tsc_crc8({8'h00, sp}, 64), sp};
   assign rx_byte = {lvl, sh[7:1]};
   assign rom_bit = ROM[bcnt[5:0]];
   assign conv_go = func_done(st, samp, bcnt, rx_byte, CMD_CONV);
   assign copy_go = func_done(st, samp, bcnt, rx_byte, CMD_COPY);

   // Bit the device puts on the line in the coming read slot
   always_comb begin
      tx_en = 1'b0;
      tx_now = 1'b1;
      case (st)
         ST_RROM: begin
            tx_en = 1'b1;
            tx_now = rom_bit;
         end
         ST_SRCH: begin
            tx_en = (ph != 2'd2);
            tx_now = (ph == 2'd0) ? rom_bit : ~rom_bit;
         end
         ST_RD: begin
            tx_en = 1'b1;
            tx_now = sp72[bcnt];
         end
         default: begin
            tx_en = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // Transaction sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         st <= ST_IDLE;
         cnt <= 11'h000;
         bcnt <= 7'h00;
         ph <= 2'd0;
         sh <= 8'h00;
         miss <= 1'b0;
      end else if (breset) begin
         st <= ST_RSTW;
         cnt <= 11'h000;
         bcnt <= 7'h00;
      end else begin
         case (st)
            ST_IDLE: begin
               cnt <= 11'h000;
            end
            ST_RSTW: begin
               if (rise) begin
                  st <= ST_PDLY;
               end
            end
            ST_PDLY: begin
               if (cnt == 11'(PDLY_CYC - 1)) begin
                  st <= ST_PRES;
                  cnt <= 11'h000;
               end else begin
                  cnt <= cnt + 11'h001;
               end
            end
            ST_PRES: begin
               if (cnt == 11'(PLEN_CYC - 1)) begin
                  st <= ST_ROMC;
                  bcnt <= 7'h00;
               end else begin
                  cnt <= cnt + 11'h001;
               end
            end
            default: begin
               if (samp) begin
                  sh <= rx_byte;
                  bcnt <= bcnt + 7'h01;
                  case (st)
                     ST_ROMC: begin
                        if (bcnt == 7'd7) begin
                           bcnt <= 7'h00;
                           ph <= 2'd0;
                           miss <= 1'b0;
                           if (rx_byte == CMD_SEARCH || (rx_byte == CMD_ALARM && alarm_flag)) begin
                              st <= ST_SRCH;
                           end else if (rx_byte == CMD_RROM) begin
                              st <= ST_RROM;
                           end else if (rx_byte == CMD_MATCH) begin
                              st <= ST_MATCH;
                           end else if (rx_byte == CMD_SKIP) begin
                              st <= ST_FUNC;
                           end else begin
                              st <= ST_IDLE;
                           end
                        end
                     end
                     ST_RROM: begin
                        if (bcnt == 7'd63) begin
                           st <= ST_FUNC;
                           bcnt <= 7'h00;
                        end
                     end
                     ST_MATCH: begin
                        if (lvl != rom_bit) begin
                           miss <= 1'b1;
                        end
                        if (bcnt == 7'd63) begin
                           st <= (miss || lvl != rom_bit) ? ST_IDLE : ST_FUNC;
                           bcnt <= 7'h00;
                        end
                     end
                     ST_SRCH: begin
                        bcnt <= bcnt;
                        if (ph != 2'd2) begin
                           ph <= ph + 2'd1;
                        end else begin
                           ph <= 2'd0;
                           // Lost arbitration or finished: wait for next init
                           if (lvl != rom_bit || bcnt == 7'd63) begin
                              st <= ST_IDLE;
                           end else begin
                              bcnt <= bcnt + 7'h01;
                           end
                        end
                     end
                     ST_FUNC: begin
                        if (bcnt == 7'd7) begin
                           bcnt <= 7'h00;
                           if (rx_byte == CMD_WR) begin
                              st <= ST_WR;
                           end else if (rx_byte == CMD_RD) begin
                              st <= ST_RD;
                           end else begin
                              st <= ST_IDLE;
                           end
                        end
                     end
                     ST_WR: begin
                        if (bcnt == 7'd23) begin
                           st <= ST_IDLE;
                        end
                     end
                     ST_RD: begin
                        if (bcnt == 7'd71) begin
                           st <= ST_IDLE;
                        end
                     end
                     default: begin
                        st <= st;
                     end
                  endcase
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Line driver: presence pulse and zero bits in read slots
   always_ff @(posedge clk) begin
      if (srst || breset) begin
         drive <= 1'b0;
      end else if (st == ST_PDLY && cnt == 11'(PDLY_CYC - 1)) begin
         drive <= 1'b1;
      end else if (st == ST_PRES && cnt == 11'(PLEN_CYC - 1)) begin
         drive <= 1'b0;
      end else if (fall && tx_en && !tx_now) begin
         drive <= 1'b1;
      end else if (samp && st != ST_PRES) begin
         drive <= 1'b0;
      end
   end

   assign dq_out = 1'b0;
   assign dq_oe = drive;

   // ==========================================================
   // Scratchpad writes and nonvolatile copy
   always_ff @(posedge clk) begin
      if (srst) begin
         th <= TH_RST;
         tl <= TL_RST;
         res <= RES_RST;
      end else if (samp && st == ST_WR && bcnt[2:0] == 3'd7) begin
         case (bcnt[4:3])
            2'd0: th <= rx_byte;
            2'd1: tl <= rx_byte;
            default: res <= {rx_byte[CFG_RH_BIT], rx_byte[CFG_RL_BIT]};
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         nv_image <= '{rsv: SP_RSV, cfg: {1'b0, RES_RST, CFG_ONES}, tl: TL_RST,
                       th: TH_RST, temp: TEMP_RST};
      end else if (copy_go) begin
         // Only thresholds and configuration are nonvolatile
         nv_image <= '{rsv: nv_image.rsv, cfg: sp.cfg, tl: sp.tl, th: sp.th,
                       temp: nv_image.temp};
      end
   end

   // ==========================================================
   // Conversion timer; shorter resolutions divide the full time
   always_ff @(posedge clk) begin
      if (srst) begin
         conv_busy <= 1'b0;
         conv_cnt <= '0;
         temp <= TEMP_RST;
         alarm_flag <= 1'b0;
      end else if (conv_go && !conv_busy) begin
         conv_busy <= 1'b1;
         conv_cnt <= CW'((CONV_CYC >> (2'd3 - res)) - 1);
      end else if (conv_busy) begin
         if (conv_cnt == '0) begin
            conv_busy <= 1'b0;
            temp <= temp_in & ~(TEMP_LSB_MASK >> res);
            alarm_flag <= ($signed(temp_in[11:4]) >= $signed(th)) ||
                          ($signed(temp_in[11:4]) <= $signed(tl));
         end else begin
            conv_cnt <= conv_cnt - CW'(1);
         end
      end
   end

   // ==========================================================
   // Checks
   cfg_fixed_a: assert property (cfg_byte[7] == 1'b0 && cfg_byte[4:0] == 5'h1f)
      else $error("config fixed bits wrong");
   sp_crc_a: assert property (tsc_crc8(sp72, 72) == 8'h00)
      else $error("scratchpad crc residue nonzero");
   rom_crc_a: assert property (tsc_crc8({8'h00, ROM}, 64) == 8'h00)
      else $error("rom crc residue nonzero");
   bus_reset_a: assert property (breset |=> st == ST_RSTW && !dq_oe)
      else $error("long low did not reset transaction");
   pres_drive_a: assert property (st == ST_PRES |-> dq_oe)
      else $error("presence pulse not driven");
   tx_zero_a: assert property (fall && tx_en && !tx_now && !breset |=> dq_oe)
      else $error("zero bit not driven");
   conv_len_a: assert property (conv_go && !conv_busy && res == 2'b00 |=>
                                conv_busy && conv_cnt == CW'(CONV_CYC / 8 - 1))
      else $error("9-bit conversion length wrong");
   alarm_set_a: assert property (conv_busy && conv_cnt == '0 |=>
      alarm_flag == ($signed($past(temp_in[11:4])) >= $signed($past(th)) ||
                     $signed($past(temp_in[11:4])) <= $signed($past(tl))))
      else $error("alarm flag mismatch");
   wr_th_a: assert property (samp && st == ST_WR && bcnt == 7'd7 && !breset |=>
                             th == $past(rx_byte))
      else $error("upper threshold not written");
   match_miss_a: assert property (st == ST_MATCH && samp && lvl != rom_bit && !breset |=>
                                  miss || st == ST_IDLE)
      else $error("mismatch not recorded");
   res_reset_a: assert property (@(posedge clk) $fell(srst) |-> res == 2'b11)
      else $error("resolution reset value wrong");

endmodule

/* File: testbench/tsc_mst.sv */
// Purpose: Behavioural bus master on the open-drain line
// Assumes: Line resolved outside; slot timing in 100 ns cycles
// Notes: Tasks are called from the bench; changes land just after an edge

module tsc_mst #(
   parameter int RST_LOW = 5000 // Reset low time in cycles
) (
   input wire logic clk, // System clock
   input wire logic line, // Resolved line level
   output logic m_low // High while master pulls low
);
   timeunit 1ns;
   timeprecision 1ns;

   initial m_low = 1'b0;

   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask

   // ==========================================================
   // Initialization: long low, then look for the answer
   task automatic bus_reset(output logic idle, output logic pres);
      m_low <= 1'b1;
      hold(RST_LOW);
      m_low <= 1'b0;
      hold(100);
      #1 idle = line;
      hold(600);
      #1 pres = line;
      hold(1000);
   endtask

   // ==========================================================
   // Slots; random idle-high gaps mimic a slow master
   task automatic send(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         m_low <= 1'b1;
         hold(v[i] ? 20 : 330);
         m_low <= 1'b0;
         hold((v[i] ? 320 : 10) + $urandom_range(15));
      end
   endtask

   // Sampled well before the device lets go of a zero
   task automatic recv(output logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         m_low <= 1'b1;
         hold(10);
         m_low <= 1'b0;
         hold(140);
         #1 v[i] = line;
         hold(190 + $urandom_range(15));
      end
   endtask
endmodule

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench for the thermometer slave
// Assumes: One slave with pullup; conversion and line reset shortened
// Notes: Expected scratchpad and CRCs are rebuilt here independently

module testbench;
   import tsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int CONV = 800;
   // Must exceed the presence pulse, else the device resets itself
   localparam int RST = 2000;
   localparam logic [7:0] FAM = 8'h5a; // Arbitrary value
   localparam logic [47:0] SER = 48'h0123_4567_89ab; // Arbitrary value

   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [15:0] temp_in = 16'h0000;
   logic dq_out, dq_oe, conv_busy, alarm_flag, m_low, line, p0, p1, alm;
   logic [7:0] th, tl, cfg, b;
   logic [71:0] rx;
   tsc_sp_t nv_image;
   tsc_sp_t sp;
   int err_count = 0;
   int compares = 0;
   int busy_n = 0;
   int e;

   // Open drain: any party low wins, pullup otherwise
   assign line = ~(m_low | dq_oe);
   always #50 clk = ~clk;
   always @(posedge clk) busy_n <= busy_n + (conv_busy ? 1 : 0);

   tsc_therm #(.FAMILY(FAM), .SERIAL(SER), .RST_CYC(RST), .CONV_CYC(CONV)) i_dut (
      .clk(clk), .srst(srst), .dq_in(line), .dq_out(dq_out), .dq_oe(dq_oe),
      .temp_in(temp_in), .conv_busy(conv_busy), .alarm_flag(alarm_flag),
      .nv_image(nv_image));
   tsc_mst #(.RST_LOW(RST + 100)) i_mst (.clk(clk), .line(line), .m_low(m_low));

   // ==========================================================
   // Checking and reporting
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   function automatic logic [7:0] ref_crc(input logic [71:0] d, input int n);
      logic [7:0] c;
      logic fb;
      c = 8'h00;
      for (int i = 0; i < n; i++) begin
         fb = c[0] ^ d[i];
         c = {fb, c[7:1]};
         c[3] = c[3] ^ fb;
         c[2] = c[2] ^ fb;
      end
      return c;
   endfunction

   task automatic init_link;
      i_mst.bus_reset(p0, p1);
      check("idle_before_presence", p0, 1'b1);
      check("presence", p1, 1'b0);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(43));
      th = $urandom;
      tl = $urandom;
      // Corner: lowest resolution, so the 9-bit timing is exercised
      cfg = $urandom & 8'h9f;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      temp_in <= $urandom;
      init_link;
      i_mst.send(CMD_SKIP);
      i_mst.send(CMD_WR);
      i_mst.send(th);
      i_mst.send(tl);
      i_mst.send(cfg);
      sp = {SP_RSV, 1'b0, cfg[6:5], CFG_ONES, tl, th, temp_in & ~(16'h0007 >> cfg[6:5])};
      alm = $signed(sp.temp[11:4]) >= $signed(th) || $signed(sp.temp[11:4]) <= $signed(tl);
      e = CONV >> (3 - cfg[6:5]);
      init_link;
      i_mst.send(CMD_SKIP);
      busy_n = 0;
      i_mst.send(CMD_CONV);
      // Master leaves the line high meanwhile, standing in for the strong pullup
      repeat (3000) begin
         @(posedge clk);
         #1;
         if (busy_n > 0 && conv_busy === 1'b0) break;
      end
      check("conv_length", busy_n >= e - 2 && busy_n <= e + 2, 1'b1);
      check("alarm", alarm_flag, alm);
      init_link;
      i_mst.send(CMD_SKIP);
      i_mst.send(CMD_RD);
      for (int i = 0; i < 9; i++) begin
         i_mst.recv(b);
         rx[i*8 +: 8] = b;
      end
      check("temp", rx[15:0], sp.temp);
      check("limits", rx[31:16], {sp.tl, sp.th});
      check("config", rx[39:32], sp.cfg);
      check("reserved", rx[63:40], sp.rsv);
      check("sp_crc", rx[71:64], ref_crc({8'h00, sp}, 64));
      init_link;
      i_mst.send(CMD_RROM);
      for (int i = 0; i < 8; i++) begin
         i_mst.recv(b);
         rx[i*8 +: 8] = b;
      end
      check("rom_id", rx[55:0], {SER, FAM});
      check("rom_crc", ref_crc(rx, 64), 8'h00);
      check("nv_reset", {nv_image.cfg, nv_image.tl, nv_image.th},
            {1'b0, RES_RST, CFG_ONES, TL_RST, TH_RST});
      i_mst.send(CMD_COPY);
      check("nv_limits", {nv_image.cfg, nv_image.tl, nv_image.th},
            {sp.cfg, sp.tl, sp.th});
      check("nv_temp", nv_image.temp, TEMP_RST);
      check("drive_level", dq_out, 1'b0);
      end_sim;
   end

   // Limit just above the expected run of about 93k cycles
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      end_sim;
   end
endmodule
